/* File: hw/arsc_pkg.sv */
// constants, register map and shared helpers for analog reference scaling
// How it works
// - scale speed reference only for analog source
// - level select: 0 unipolar, 1 bipolar
// - main gain: value at 10 V
// - main bias: value at 0 V, signed
// - aux function code 0 to 1f, default f
// - aux gain: function value at 10 V
// - aux bias: function value at 0 V
// - first-order lag on all four inputs
// - function 1 multiplies the main gain
// - function 2 adds bias to reference
package arsc_pkg;

	// parameter register numbers as seen on the access port
	localparam logic [15:0] REG_MAIN_REF_LEVEL_SEL = 16'h0450;
	localparam logic [15:0] REG_MAIN_REF_GAIN      = 16'h0451;
	localparam logic [15:0] REG_MAIN_REF_BIAS      = 16'h0452;
	localparam logic [15:0] REG_AUX2_LEVEL_SEL     = 16'h0453;
	localparam logic [15:0] REG_AUX2_FUNCTION_SEL  = 16'h0454;
	localparam logic [15:0] REG_AUX2_GAIN          = 16'h0455;
	localparam logic [15:0] REG_AUX2_BIAS          = 16'h0456;
	localparam logic [15:0] REG_AUX3_LEVEL_SEL     = 16'h0457;
	localparam logic [15:0] REG_AUX3_FUNCTION_SEL  = 16'h0458;
	localparam logic [15:0] REG_AUX3_GAIN          = 16'h0459;
	localparam logic [15:0] REG_AUX3_BIAS          = 16'h045a;
	localparam logic [15:0] REG_AUX4_LEVEL_SEL     = 16'h045b;
	localparam logic [15:0] REG_AUX4_FUNCTION_SEL  = 16'h045c;
	localparam logic [15:0] REG_AUX4_GAIN          = 16'h045d;
	localparam logic [15:0] REG_AUX4_BIAS          = 16'h045e;
	localparam logic [15:0] REG_INPUT_FILTER_TIME  = 16'h045f;

	// register file shape
	localparam int          REG_COUNT     = 16;
	localparam logic [3:0]  IDX_MAIN_LEVEL = 4'h0;
	localparam logic [3:0]  IDX_MAIN_GAIN  = 4'h1;
	localparam logic [3:0]  IDX_MAIN_BIAS  = 4'h2;
	localparam logic [3:0]  IDX_AUX_BASE   = 4'h3;
	localparam logic [3:0]  IDX_FILTER     = 4'hf;
	localparam int          AUX_COUNT      = 3;
	localparam int          AUX_STRIDE     = 4;
	localparam logic [1:0]  AUX_LEVEL_OFS  = 2'h0;
	localparam logic [1:0]  AUX_FUNC_OFS   = 2'h1;
	localparam logic [1:0]  AUX_GAIN_OFS   = 2'h2;
	localparam logic [1:0]  AUX_BIAS_OFS   = 2'h3;

	// factory values; gain and bias in 0.1 % steps
	localparam logic [15:0] LEVEL_RST  = 16'h0000;
	localparam logic [15:0] FUNC_RST   = 16'h000f;
	localparam logic [15:0] GAIN_RST   = 16'h03e8;
	localparam logic [15:0] BIAS_RST   = 16'h0000;
	localparam logic [15:0] FILTER_RST = 16'h0000;

	// accepted write ranges
	localparam logic [15:0]        LEVEL_MAX  = 16'h0001;
	localparam logic [15:0]        FUNC_MAX   = 16'h001f;
	localparam logic [15:0]        GAIN_MAX   = 16'h2710;
	localparam logic signed [15:0] BIAS_MIN   = -16'sh03e8;
	localparam logic signed [15:0] BIAS_MAX   = 16'sh03e8;
	localparam logic [15:0]        FILTER_MAX = 16'h00c8;

	// source select and function codes
	localparam logic [3:0] REF_SRC_ANALOG = 4'h1;
	localparam logic [4:0] FUNC_FREQ_GAIN = 5'h01;
	localparam logic [4:0] FUNC_FREQ_BIAS = 5'h02;

	// datapath: input code 8192 equals 10 V, values in 0.1 %
	localparam int IN_W     = 16;
	localparam int VAL_W    = 24;
	localparam int FS_SHIFT = 13;
	localparam int PCT_ONE  = 1000;

	// lag filter timing; one time-constant lsb is 0.01 s
	localparam int CLK_PERIOD_NS      = 10;
	localparam int FILTER_LSB_NS      = 10000000;
	localparam int LAG_SHIFT          = 4;
	localparam int FILTER_LSB_CYCLES  = FILTER_LSB_NS / CLK_PERIOD_NS;
	localparam int FILTER_STEP_CYCLES = FILTER_LSB_CYCLES >> LAG_SHIFT;

	// saturate a wide signed value to the value width
	function automatic logic signed [VAL_W-1:0] arsc_sat(input logic signed [47:0] x);
		logic signed [47:0] hi;
		logic signed [47:0] lo;
		hi = 48'sd1 <<< (VAL_W - 1);
		lo = -hi;
		if (x >= hi) begin
			arsc_sat = {1'b0, {(VAL_W-1){1'b1}}};
		end else if (x < lo) begin
			arsc_sat = {1'b1, {(VAL_W-1){1'b0}}};
		end else begin
			arsc_sat = x[VAL_W-1:0];
		end
	endfunction : arsc_sat

endpackage : arsc_pkg

/* File: hw/arsc_lag_filter.sv */
// first-order lag filter for one analog reading
`timescale 1ns/1ps
module arsc_lag_filter
	import arsc_pkg::*;
(
	// clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  rst,
	// control
	input  wire logic                  step,    // one filter update
	input  wire logic                  bypass,  // zero time constant
	// data
	input  wire logic signed [IN_W-1:0] din,
	output logic signed [IN_W-1:0]      dout
);

	localparam int ACC_W = IN_W + LAG_SHIFT;

	logic signed [ACC_W-1:0] acc;   // output scaled up by the lag shift
	logic signed [ACC_W-1:0] diff;  // input minus present output

	// error term, widened so it never wraps
	always_comb begin
		diff = ACC_W'(din) - ACC_W'(dout);
	end

	// each step closes 1/16 of the gap; bypass tracks the input directly
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			acc <= '0;
		end else if (bypass) begin
			acc <= {din, {LAG_SHIFT{1'b0}}};
		end else if (step) begin
			acc <= acc + diff;
		end
	end

	assign dout = acc[ACC_W-1:LAG_SHIFT];

endmodule : arsc_lag_filter

/* File: hw/arsc_scaler.sv */
// linear gain/bias scaling of one filtered reading
`timescale 1ns/1ps
module arsc_scaler
	import arsc_pkg::*;
(
	// clock and reset
	input  wire logic                    sys_clk,
	input  wire logic                    rst,
	// settings
	input  wire logic                    bipolar,  // level select bit
	input  wire logic signed [VAL_W-1:0] gain,     // value at 10 V
	input  wire logic signed [VAL_W-1:0] bias,     // value at 0 V
	// data
	input  wire logic signed [IN_W-1:0]  vin,
	output logic signed [VAL_W-1:0]      vout
);

	logic signed [47:0] v_eff;  // reading after level clipping
	logic signed [47:0] span;   // gain minus bias
	logic signed [47:0] prod;   // span times reading
	logic signed [VAL_W-1:0] next_vout;

	// unipolar inputs ignore the negative half
	always_comb begin
		if (!bipolar && vin < 0) begin
			v_eff = '0;
		end else begin
			v_eff = 48'(vin);
		end
		span      = 48'(gain) - 48'(bias);
		prod      = span * v_eff;
		next_vout = arsc_sat(48'(bias) + (prod >>> FS_SHIFT));
	end

	// registered result
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			vout <= '0;
		end else begin
			vout <= next_vout;
		end
	end

endmodule : arsc_scaler

/* File: hw/arsc_top.sv */
// analog input filtering, scaling and speed reference forming
`timescale 1ns/1ps
module arsc_top
	import arsc_pkg::*;
#(
	parameter int STEP_UNIT_CYCLES = FILTER_STEP_CYCLES  // cycles per step per 0.01 s of time constant
)(
	// clock and reset
	input  wire logic                    sys_clk,
	input  wire logic                    rst,
	// parameter access port
	input  wire logic                    reg_wr,
	input  wire logic                    reg_rd,
	input  wire logic [15:0]             reg_addr,
	input  wire logic [15:0]             reg_wdata,
	output logic [15:0]                  reg_rdata,
	output logic                         reg_ack,
	output logic                         reg_err,
	// reference source selection
	input  wire logic [3:0]              reference_source_select,
	// converted readings, same clock
	input  wire logic signed [IN_W-1:0]  main_reference_input,
	input  wire logic signed [IN_W-1:0]  aux_input_two,
	input  wire logic signed [IN_W-1:0]  aux_input_three,
	input  wire logic signed [IN_W-1:0]  aux_input_four,
	// results
	output logic signed [VAL_W-1:0]      speed_ref,
	output logic                         speed_ref_active,
	output logic signed [VAL_W-1:0]      aux2_value,
	output logic signed [VAL_W-1:0]      aux3_value,
	output logic signed [VAL_W-1:0]      aux4_value
);

	logic [15:0] cfg [REG_COUNT];   // parameter storage
	logic [3:0]  acc_idx;           // register index of the access
	logic        acc_hit;           // address falls in the map
	logic [31:0] step_cnt;          // filter step timer
	logic [31:0] step_period;       // cycles between filter steps
	logic        step;              // one-cycle filter update
	logic        bypass;            // zero time constant

	logic signed [IN_W-1:0]  raw   [AUX_COUNT+1];  // captured readings
	logic signed [IN_W-1:0]  filt  [AUX_COUNT+1];  // filtered readings
	logic signed [VAL_W-1:0] aux_val [AUX_COUNT];  // scaled aux values
	logic signed [VAL_W-1:0] gain_eff;             // main gain after multipliers
	logic signed [VAL_W-1:0] bias_sum;             // sum of frequency biases
	logic signed [VAL_W-1:0] main_val;             // scaled main reading
	logic signed [VAL_W-1:0] next_gain_eff;
	logic signed [VAL_W-1:0] next_bias_sum;

	// register number to index
	function automatic logic [3:0] reg_index(input logic [15:0] addr);
		logic [15:0] d;
		d = addr - REG_MAIN_REF_LEVEL_SEL;
		reg_index = d[3:0];
	endfunction : reg_index

	// which field kind an index is; main level/gain/bias map like aux
	function automatic logic [1:0] reg_kind(input logic [3:0] idx);
		logic [3:0] d;
		d = idx - IDX_AUX_BASE;
		if (idx == IDX_MAIN_LEVEL) begin
			reg_kind = AUX_LEVEL_OFS;
		end else if (idx == IDX_MAIN_GAIN) begin
			reg_kind = AUX_GAIN_OFS;
		end else if (idx == IDX_MAIN_BIAS) begin
			reg_kind = AUX_BIAS_OFS;
		end else begin
			reg_kind = d[1:0];
		end
	endfunction : reg_kind

	// factory value of a register
	function automatic logic [15:0] reset_value(input logic [3:0] idx);
		if (idx == IDX_FILTER) begin
			reset_value = FILTER_RST;
		end else begin
			case (reg_kind(idx))
				AUX_LEVEL_OFS: reset_value = LEVEL_RST;
				AUX_FUNC_OFS:  reset_value = FUNC_RST;
				AUX_GAIN_OFS:  reset_value = GAIN_RST;
				default:       reset_value = BIAS_RST;
			endcase
		end
	endfunction : reset_value

	// whether a write value lies in the documented range
	function automatic logic value_ok(input logic [3:0] idx, input logic [15:0] v);
		if (idx == IDX_FILTER) begin
			value_ok = (v <= FILTER_MAX);
		end else begin
			case (reg_kind(idx))
				AUX_LEVEL_OFS: value_ok = (v <= LEVEL_MAX);
				AUX_FUNC_OFS:  value_ok = (v <= FUNC_MAX);
				AUX_GAIN_OFS:  value_ok = (v <= GAIN_MAX);
				default:       value_ok = ($signed(v) >= BIAS_MIN) && ($signed(v) <= BIAS_MAX);
			endcase
		end
	endfunction : value_ok

	// index of an aux field
	function automatic logic [3:0] aux_idx(input int k, input logic [1:0] ofs);
		aux_idx = IDX_AUX_BASE + 4'(k * AUX_STRIDE) + 4'(ofs);
	endfunction : aux_idx

	// address decode
	always_comb begin
		acc_idx = reg_index(reg_addr);
		acc_hit = (reg_addr >= REG_MAIN_REF_LEVEL_SEL) && (reg_addr <= REG_INPUT_FILTER_TIME);
	end

	// parameter writes; out-of-range or unmapped writes are dropped
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < REG_COUNT; i++) begin
				cfg[i] <= reset_value(4'(i));
			end
		end else if (reg_wr && acc_hit && value_ok(acc_idx, reg_wdata)) begin
			cfg[acc_idx] <= reg_wdata;
		end
	end

	// access answer one cycle after the request
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= '0;
			reg_ack   <= 1'b0;
			reg_err   <= 1'b0;
		end else begin
			reg_ack   <= reg_wr | reg_rd;
			reg_err   <= (reg_wr | reg_rd) & ~acc_hit
			             | reg_wr & acc_hit & ~value_ok(acc_idx, reg_wdata);
			if (reg_rd && acc_hit) begin
				reg_rdata <= cfg[acc_idx];
			end else if (reg_rd) begin
				reg_rdata <= '0;  // unmapped reads return zero
			end
		end
	end

	// step period follows the time-constant register
	always_comb begin
		step_period = 32'(cfg[IDX_FILTER]) * 32'(STEP_UNIT_CYCLES);
		bypass      = (cfg[IDX_FILTER] == FILTER_RST);
	end

	// filter step timer, held at zero while bypassed
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			step_cnt <= '0;
			step     <= 1'b0;
		end else if (bypass || step_cnt >= step_period - 32'd1) begin
			step_cnt <= '0;
			step     <= ~bypass;
		end else begin
			step_cnt <= step_cnt + 32'd1;
			step     <= 1'b0;
		end
	end

	// capture the readings
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i <= AUX_COUNT; i++) begin
				raw[i] <= '0;
			end
		end else begin
			raw[0] <= main_reference_input;
			raw[1] <= aux_input_two;
			raw[2] <= aux_input_three;
			raw[3] <= aux_input_four;
		end
	end

	// one lag filter per terminal, sharing the time constant
	for (genvar g = 0; g <= AUX_COUNT; g++) begin : g_filt
		arsc_lag_filter u_filt (
			.sys_clk (sys_clk),
			.rst     (rst),
			.step    (step),
			.bypass  (bypass),
			.din     (raw[g]),
			.dout    (filt[g])
		);
	end

	// aux terminals scaled by their own gain and bias
	for (genvar g = 0; g < AUX_COUNT; g++) begin : g_aux
		arsc_scaler u_scale (
			.sys_clk (sys_clk),
			.rst     (rst),
			.bipolar (cfg[aux_idx(g, AUX_LEVEL_OFS)][0]),
			.gain    (VAL_W'(cfg[aux_idx(g, AUX_GAIN_OFS)])),
			.bias    (VAL_W'($signed(cfg[aux_idx(g, AUX_BIAS_OFS)]))),
			.vin     (filt[g+1]),
			.vout    (aux_val[g])
		);
	end

	// combine aux functions into main gain and added bias
	always_comb begin
		logic signed [47:0] g_acc;
		logic signed [47:0] b_acc;
		logic [4:0]         code;
		g_acc = 48'(cfg[IDX_MAIN_GAIN]);
		b_acc = '0;
		code  = '0;
		for (int k = 0; k < AUX_COUNT; k++) begin
			code = cfg[aux_idx(k, AUX_FUNC_OFS)][4:0];
			if (code == FUNC_FREQ_GAIN) begin
				g_acc = (g_acc * 48'(aux_val[k])) / 48'sd1000;
			end else if (code == FUNC_FREQ_BIAS) begin
				b_acc = b_acc + 48'(aux_val[k]);
			end
		end
		next_gain_eff = arsc_sat(g_acc);
		next_bias_sum = arsc_sat(b_acc);
	end

	// combined terms registered
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			gain_eff <= '0;
			bias_sum <= '0;
		end else begin
			gain_eff <= next_gain_eff;
			bias_sum <= next_bias_sum;
		end
	end

	// main terminal scaled with its effective gain
	arsc_scaler u_main (
		.sys_clk (sys_clk),
		.rst     (rst),
		.bipolar (cfg[IDX_MAIN_LEVEL][0]),
		.gain    (gain_eff),
		.bias    (VAL_W'($signed(cfg[IDX_MAIN_BIAS]))),
		.vin     (filt[0]),
		.vout    (main_val)
	);

	// speed reference only while the analog source is selected
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			speed_ref        <= '0;
			speed_ref_active <= 1'b0;
		end else if (reference_source_select == REF_SRC_ANALOG) begin
			speed_ref        <= arsc_sat(48'(main_val) + 48'(bias_sum));
			speed_ref_active <= 1'b1;
		end else begin
			speed_ref        <= '0;
			speed_ref_active <= 1'b0;
		end
	end

	// scaled aux values for other functions
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			aux2_value <= '0;
			aux3_value <= '0;
			aux4_value <= '0;
		end else begin
			aux2_value <= aux_val[0];
			aux3_value <= aux_val[1];
			aux4_value <= aux_val[2];
		end
	end

endmodule : arsc_top

/* File: test/arsc_monitor.sv */
// checker for the access port and the reference flags of arsc_top
`timescale 1ns/1ps
module arsc_monitor
	import arsc_pkg::*;
(
	// clock and reset
	input wire logic                    sys_clk,
	input wire logic                    rst,
	// access port
	input wire logic                    reg_wr,
	input wire logic                    reg_rd,
	input wire logic [15:0]             reg_addr,
	input wire logic [15:0]             reg_wdata,
	input wire logic                    reg_ack,
	input wire logic                    reg_err,
	// reference
	input wire logic [3:0]              reference_source_select,
	input wire logic signed [VAL_W-1:0] speed_ref,
	input wire logic                    speed_ref_active
);
	// all checks on one clock, quiet during reset
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// each request is answered on the next edge
	chk_ack_follows: assert property ((reg_wr || reg_rd) |=> reg_ack)
		else $error("no ack after request");
	// no answer without a request
	chk_ack_alone: assert property (!(reg_wr || reg_rd) |=> !reg_ack && !reg_err)
		else $error("ack or err without request");
	chk_level_range: assert property (
		(reg_wr && reg_addr == REG_MAIN_REF_LEVEL_SEL && reg_wdata > LEVEL_MAX) |=> reg_err)
		else $error("bad level write not refused");
	chk_gain_range: assert property (
		(reg_wr && reg_addr == REG_MAIN_REF_GAIN && reg_wdata > GAIN_MAX) |=> reg_err)
		else $error("bad gain write not refused");
	chk_bias_range: assert property (
		(reg_wr && reg_addr == REG_MAIN_REF_BIAS && ($signed(reg_wdata) > BIAS_MAX
		|| $signed(reg_wdata) < BIAS_MIN)) |=> reg_err)
		else $error("bad bias write not refused");
	chk_func_range: assert property (
		(reg_wr && reg_addr == REG_AUX2_FUNCTION_SEL && reg_wdata > FUNC_MAX) |=> reg_err)
		else $error("bad function write not refused");
	chk_func_good: assert property (
		(reg_wr && reg_addr == REG_AUX2_FUNCTION_SEL && reg_wdata <= FUNC_MAX) |=> !reg_err)
		else $error("good function write refused");
	chk_filter_range: assert property (
		(reg_wr && reg_addr == REG_INPUT_FILTER_TIME && reg_wdata > FILTER_MAX) |=> reg_err)
		else $error("bad filter write not refused");
	chk_src_active: assert property (
		(reference_source_select == REF_SRC_ANALOG) |=> speed_ref_active)
		else $error("reference not active");
	chk_src_idle: assert property (
		(reference_source_select != REF_SRC_ANALOG) |=> !speed_ref_active && speed_ref == '0)
		else $error("reference not idle");
	// main scenarios
	cov_write: cover property (reg_wr ##1 reg_ack);
	cov_err: cover property (reg_err);
	cov_active: cover property (speed_ref_active && speed_ref != '0);
endmodule : arsc_monitor

bind arsc_top arsc_monitor arsc_monitor_i (.sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_ack(reg_ack),
	.reg_err(reg_err), .reference_source_select(reference_source_select),
	.speed_ref(speed_ref), .speed_ref_active(speed_ref_active));

/* File: test/arsc_src_model.sv */
// behavioural model of the four analog reference sources
`timescale 1ns/1ps
module arsc_src_model
	import arsc_pkg::*;
(
	// clock and reset
	input wire logic                  sys_clk,
	input wire logic                  rst,
	// wanted levels, 8192 is 10 V
	input wire logic [3:0][IN_W-1:0]  level,
	// converted readings
	output logic [3:0][IN_W-1:0]      rd
);
	// a source cannot pass +-10 V; conversion takes one cycle
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rd <= '0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if ($signed(level[i]) > 16'sd8192) rd[i] <= 16'h2000;
				else if ($signed(level[i]) < -16'sd8192) rd[i] <= 16'he000;
				else rd[i] <= level[i];
			end
		end
	end
endmodule : arsc_src_model

/* File: test/arsc_top_tb.sv */
// self-checking bench for analog reference scaling
`timescale 1ns/1ps
module arsc_top_tb
	import arsc_pkg::*;
;
	logic                    sys_clk, rst, reg_wr, reg_rd, reg_ack, reg_err, act;
	logic [15:0]             reg_addr, reg_wdata, reg_rdata;
	logic [3:0]              src;   // source select
	logic [3:0][15:0]        tgt, rd;  // source levels and readings
	logic signed [VAL_W-1:0] sref, a2, a3, a4;
	logic [31:0]             seed = 32'h3bd8;
	int                      err_total, samples_checked;
	longint                  g, b, x, y;
	// short filter step so lag runs are brief
	arsc_top #(.STEP_UNIT_CYCLES(4)) arsc_top_i (.sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_err(reg_err),
		.reference_source_select(src), .main_reference_input(rd[0]), .aux_input_two(rd[1]),
		.aux_input_three(rd[2]), .aux_input_four(rd[3]), .speed_ref(sref), .speed_ref_active(act),
		.aux2_value(a2), .aux3_value(a3), .aux4_value(a4));
	arsc_src_model arsc_src_model_i (.sys_clk(sys_clk), .rst(rst), .level(tgt), .rd(rd));
	// clock
	initial begin
		sys_clk = 0;
		forever #5 sys_clk = ~sys_clk;
	end
	// next random word
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nxt
	// expected linear scaling, negatives clipped when unipolar
	function automatic longint scl(input longint v, gn, bs, input bit bip);
		if (!bip && v < 0) v = 0;
		return bs + (((gn - bs) * v) >>> 13);
	endfunction : scl
	task automatic cmp_word(input logic [15:0] got, exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %0t %s got %0h exp %0h", $time, m, got, exp);
		end
	endtask : cmp_word
	task automatic cmp_val(input logic [23:0] got, input longint exp, input string m);
		samples_checked++;
		if (got !== exp[23:0]) begin
			err_total++;
			$display("CHECK FAILED %0t %s got %0d exp %0d", $time, m, $signed(got), exp);
		end
	endtask : cmp_val
	// one register write, refusal checked
	task automatic wr(input logic [15:0] a, d, input logic e);
		@(posedge sys_clk);
		reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 0;
		#1 cmp_word({15'h0, reg_ack & reg_err}, {15'h0, e}, "write err");
	endtask : wr
	// one register read with expected word
	task automatic rdc(input logic [15:0] a, d, input logic e);
		@(posedge sys_clk);
		reg_rd <= 1; reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 0;
		#1 cmp_word({15'h0, reg_ack & reg_err}, {15'h0, e}, "read err");
		cmp_word(reg_rdata, d, "read data");
	endtask : rdc
	task automatic settle;
		repeat (12) @(posedge sys_clk);
		#1;
	endtask : settle
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : wrap_up
	// hang guard, well beyond the few thousand cycles needed
	initial begin
		#200000;
		err_total++;
		wrap_up();
	end
	initial begin
		{rst, reg_wr, reg_rd, reg_addr, reg_wdata, src, tgt} = '0;
		rst = 1;
		repeat (12) @(posedge sys_clk);
		rst <= 0;
		// factory values of all sixteen registers
		for (int i = 0; i < 16; i++)
			rdc(16'h0450 + i[15:0], (i == 1 || (i > 2 && i < 15 && (i - 3) % 4 == 2)) ? GAIN_RST :
				(i > 2 && i < 15 && (i - 3) % 4 == 1) ? FUNC_RST : 16'h0, 0);
		rdc(16'h0460, 0, 1);
		wr(REG_MAIN_REF_LEVEL_SEL, 16'h2, 1);
		wr(REG_MAIN_REF_GAIN, 16'h2711, 1);
		wr(REG_MAIN_REF_BIAS, 16'hfc17, 1);
		wr(REG_AUX3_GAIN, 16'h2711, 1);
		wr(REG_AUX4_BIAS, 16'h03e9, 1);
		wr(REG_INPUT_FILTER_TIME, 16'h00c9, 1);
		rdc(REG_MAIN_REF_GAIN, GAIN_RST, 0);
		// function codes 15 to 31 are accepted, 32 is refused
		for (int c = 32; c >= 15; c--) wr(REG_AUX2_FUNCTION_SEL, c[15:0], c > 31);
		@(posedge sys_clk);
		src <= 1;
		// random main scaling, first trial a clipped negative
		for (int n = 0; n < 6; n++) begin
			// widen before subtracting so negative draws stay negative
			seed = nxt(seed); g = seed % 10001; seed = nxt(seed); b = longint'(seed % 2001) - 1000;
			seed = nxt(seed); x = (n == 0) ? -4096 : longint'(seed % 16385) - 8192;
			wr(REG_MAIN_REF_GAIN, g[15:0], 0);
			wr(REG_MAIN_REF_BIAS, b[15:0], 0);
			wr(REG_MAIN_REF_LEVEL_SEL, {15'h0, n[0]}, 0);
			tgt[0] <= x[15:0];
			settle();
			cmp_val(sref, scl(x, g, b, n[0]), "main scaling");
			cmp_word({15'h0, act}, 16'h1, "active");
		end
		// aux two as frequency bias, bipolar
		wr(REG_MAIN_REF_GAIN, 16'd1000, 0);
		wr(REG_MAIN_REF_BIAS, 16'h0, 0);
		wr(REG_MAIN_REF_LEVEL_SEL, 16'h0, 0);
		wr(REG_AUX2_FUNCTION_SEL, 16'h2, 0);
		wr(REG_AUX2_LEVEL_SEL, 16'h1, 0);
		wr(REG_AUX2_GAIN, 16'd800, 0);
		wr(REG_AUX2_BIAS, 16'hff38, 0);
		seed = nxt(seed); y = longint'(seed % 16385) - 8192;
		tgt[0] <= 16'd4096; tgt[1] <= y[15:0];
		settle();
		cmp_val(a2, scl(y, 800, -200, 1), "aux2 value");
		cmp_val(sref, 500 + scl(y, 800, -200, 1), "bias sum");
		// aux three as frequency gain
		wr(REG_AUX2_FUNCTION_SEL, 16'hf, 0);
		wr(REG_AUX3_FUNCTION_SEL, 16'h1, 0);
		seed = nxt(seed); y = seed % 8192;
		tgt[2] <= y[15:0];
		settle();
		cmp_val(a3, scl(y, 1000, 0, 0), "aux3 value");
		cmp_val(sref, scl(4096, 1000 * scl(y, 1000, 0, 0) / 1000, 0, 0), "gain product");
		// other source: reference idle
		src <= 0;
		settle();
		cmp_val(sref, 0, "idle ref");
		cmp_word({15'h0, act}, 16'h0, "idle flag");
		// lag on aux four after a full-scale step
		wr(REG_INPUT_FILTER_TIME, 16'h1, 0);
		tgt[3] <= 16'h2000;
		settle();
		cmp_word({15'h0, a4 < 24'sd900}, 16'h1, "lag slow");
		repeat (2000) @(posedge sys_clk);
		#1;
		cmp_word({15'h0, a4 >= 24'sd998 && a4 <= 24'sd1000}, 16'h1, "lag end");
		wr(REG_INPUT_FILTER_TIME, 16'h0, 0);
		tgt[3] <= 16'd4096;
		settle();
		cmp_val(a4, 500, "no lag");
		// second reset restores factory values
		rst <= 1;
		repeat (2) @(posedge sys_clk);
		rst <= 0;
		rdc(REG_AUX3_FUNCTION_SEL, FUNC_RST, 0);
		wrap_up();
	end
endmodule : arsc_top_tb
